// ### rtl/bsc_defs.svh
/*
 * register offsets, field positions, reset values and cycle counts
 * assumes: included by bare name from the core and the bench
 */
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

// apb byte offsets
`define BSC_OFF_CTRL     12'h000
`define BSC_OFF_STATUS_FLAG_REGISTER     12'h004
`define BSC_OFF_PC       12'h008
`define BSC_OFF_XPTR     12'h00c
`define BSC_OFF_STAT     12'h010

// control register fields
`define BSC_CTRL_RUN     0
`define BSC_CTRL_RST     32'h0000_0000

// status flag register bit positions
`define BSC_FLG_C        0
`define BSC_FLG_Z        1
`define BSC_FLG_N        2
`define BSC_FLG_V        3
`define BSC_FLG_S        4
`define BSC_FLG_H        5
`define BSC_FLG_T        6
`define BSC_FLG_I        7
`define BSC_STATUS_FLAG_REGISTER_RST     8'h00
`define BSC_PC_RST       16'h0000
`define BSC_XPTR_RST     16'h0000

// instruction cycle counts
`define BSC_CYC_CMP      2'd1
`define BSC_CYC_NOSKIP   2'd1
`define BSC_CYC_SKIP1    2'd2
`define BSC_CYC_SKIP2    2'd3
`define BSC_CYC_BR_NOT   2'd1
`define BSC_CYC_BR_TAKEN 2'd2
`define BSC_CYC_LOAD     2'd2

`endif

// ### rtl/bsc_pkg.sv
/*
 * types shared by the execution core
 * assumes: fetch presents one pre-decoded operation per transfer
 */
package bsc_pkg;

    // pre-decoded operation presented by fetch
    typedef enum logic [3:0] {
        plain_compare_op        = 4'h0,
        compare_with_carry_op   = 4'h1,
        compare_immediate_op    = 4'h2,
        skip_reg_bit_clear_op   = 4'h3,
        skip_reg_bit_set_op     = 4'h4,
        skip_io_bit_clear_op    = 4'h5,
        skip_io_bit_set_op      = 4'h6,
        branch_flag_set_op      = 4'h7,
        branch_flag_clear_op    = 4'h8,
        indirect_load_op        = 4'h9,
        indirect_load_inc_op    = 4'ha,
        indirect_load_dec_op    = 4'hb
    } bsc_op_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_LOAD = 3'b100
    } bsc_state_t;

endpackage

// ### rtl/bsc_core.sv
/*
 * execution core for compares, skips, relative branches and x loads,
 * with an apb slave for control, status flags, pc and x pointer.
 * assumes: operands already read from the register file and i/o space;
 * data memory answers combinationally while mem_req is high.
 */
// The placing of the registers and the APB slave port were decided locally.
// What this block does
// - compare-with-carry and compare-immediate set Z,N,V,C,H, drop result, 1 cycle
// - skip when register bit is 0, pc advances 2 or 3
// - skip when register bit is 1, pc advances 2 or 3
// - skip when i/o bit is 0, flags untouched
// - skip when i/o bit is 1, flags untouched
// - flag-set branch jumps to pc+k+1 when indexed flag is 1
// - flag-clear branch jumps to pc+k+1 when indexed flag is 0
// - equal branches on Z=1, not-equal on Z=0
// - carry-set and lower branches on C=1
// - carry-clear and same-or-higher branches on C=0
// - minus branches on N=1, plus on N=0
// - signed greater-or-equal branches when N xor V is 0
// - signed less-than branches when N xor V is 1
// - half-carry branches test H set or clear
// - transfer-bit branches test T set or clear
// - overflow branches test V set or clear
// - interrupt branches test I set or clear
// - post-increment load reads at X then bumps X, 2 cycles
// - pre-decrement load lowers X first then reads, 2 cycles
// - plain compare subtracts registers, sets flags, 1 cycle
`include "bsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module bsc_core #(
    parameter int PC_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             op_valid,
    output logic                  op_ready,
    input  wire bsc_pkg::bsc_op_t op_code,
    input  wire logic [7:0]       op_a,
    input  wire logic [7:0]       op_b,
    input  wire logic [2:0]       op_bit,
    input  wire logic [6:0]       op_off,
    input  wire logic             op_io_bit,
    input  wire logic             op_next_two,
    output logic                  mem_req,
    output logic      [15:0]      mem_addr,
    input  wire logic [7:0]       mem_rdata,
    output logic                  rf_we,
    output logic      [7:0]       rf_wdata,
    output logic      [PC_W-1:0]  pc
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // flag picked by a branch index; S slot means N xor V
    function automatic logic flag_sel(input logic [7:0] f,
                                      input logic [2:0] idx);
        if (idx == 3'(`BSC_FLG_S))
            flag_sel = f[`BSC_FLG_N] ^ f[`BSC_FLG_V];
        else
            flag_sel = f[idx];
    endfunction

    // a - b - cin into C,Z,N,V,S,H; chain keeps Z for carry
    function automatic logic [7:0] sub_flags(input logic [7:0] f,
                                             input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       cin,
                                             input logic       chain);
        logic [8:0] d;
        logic [7:0] r;
        logic       n;
        logic       v;
        d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        r = d[7:0];
        n = r[7];
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        sub_flags = f;
        sub_flags[`BSC_FLG_C] = d[8];
        sub_flags[`BSC_FLG_Z] = (r == 8'h00) &
                                (chain ? f[`BSC_FLG_Z] : 1'b1);
        sub_flags[`BSC_FLG_N] = n;
        sub_flags[`BSC_FLG_V] = v;
        sub_flags[`BSC_FLG_S] = n ^ v;
        sub_flags[`BSC_FLG_H] = (~a[3] & b[3]) | (b[3] & r[3]) |
                                (r[3] & ~a[3]);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // core state

    bsc_pkg::bsc_state_t state_ff, nxt_state;
    logic [1:0]      hold_ff,   nxt_hold;
    logic [7:0]      status_flag_register_ff,   nxt_status_flag_register;
    logic [PC_W-1:0] pc_ff,     nxt_pc;
    logic [15:0]     x_ff,      nxt_x;
    logic            ready_ff,  nxt_ready;
    logic            req_ff,    nxt_req;
    logic [15:0]     addr_ff,   nxt_addr;
    logic            we_ff,     nxt_we;
    logic [7:0]      wdata_ff,  nxt_wdata;
    logic [1:0]      lastcyc_ff, nxt_lastcyc;
    logic            taken_ff,  nxt_taken;
    logic [31:0]     ctrl_ff,   nxt_ctrl;
    logic            run;
    logic            acc;
    logic            cond;
    logic [PC_W-1:0] br_tgt;
    logic            sw_we;
    logic [11:0]     sw_off;

    assign run = ctrl_ff[`BSC_CTRL_RUN];
    assign acc = op_valid & ready_ff;
    // signed word displacement onto pc+1
    assign br_tgt = pc_ff + PC_W'(1) +
                    PC_W'({{(PC_W-7){op_off[6]}}, op_off});

    // skip or branch condition of the operation on offer
    always_comb
    begin
        unique case (op_code)
            bsc_pkg::skip_reg_bit_clear_op: cond = ~op_a[op_bit];
            bsc_pkg::skip_reg_bit_set_op:   cond = op_a[op_bit];
            bsc_pkg::skip_io_bit_clear_op:  cond = ~op_io_bit;
            bsc_pkg::skip_io_bit_set_op:    cond = op_io_bit;
            bsc_pkg::branch_flag_set_op:
                cond = flag_sel(status_flag_register_ff, op_bit);
            bsc_pkg::branch_flag_clear_op:
                cond = ~flag_sel(status_flag_register_ff, op_bit);
            default:                        cond = 1'b0;
        endcase
    end

    // next values of the sequencer, flags, pc and x pointer
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_hold    = hold_ff;
        nxt_status_flag_register    = status_flag_register_ff;
        nxt_pc      = pc_ff;
        nxt_x       = x_ff;
        nxt_req     = 1'b0;
        nxt_addr    = addr_ff;
        nxt_we      = 1'b0;
        nxt_wdata   = wdata_ff;
        nxt_lastcyc = lastcyc_ff;
        nxt_taken   = taken_ff;
        unique case (state_ff)
            bsc_pkg::ST_IDLE:
            begin
                if (acc)
                begin
                    nxt_taken = cond;
                    nxt_pc    = pc_ff + PC_W'(1);
                    unique case (op_code)
                        bsc_pkg::plain_compare_op:
                        begin
                            nxt_status_flag_register = sub_flags(status_flag_register_ff, op_a, op_b,
                                                 1'b0, 1'b0);
                            nxt_lastcyc = `BSC_CYC_CMP;
                        end
                        bsc_pkg::compare_with_carry_op:
                        begin
                            nxt_status_flag_register = sub_flags(status_flag_register_ff, op_a, op_b,
                                status_flag_register_ff[`BSC_FLG_C], 1'b1);
                            nxt_lastcyc = `BSC_CYC_CMP;
                        end
                        bsc_pkg::compare_immediate_op:
                        begin
                            nxt_status_flag_register = sub_flags(status_flag_register_ff, op_a, op_b,
                                                 1'b0, 1'b0);
                            nxt_lastcyc = `BSC_CYC_CMP;
                        end
                        bsc_pkg::skip_reg_bit_clear_op,
                        bsc_pkg::skip_reg_bit_set_op,
                        bsc_pkg::skip_io_bit_clear_op,
                        bsc_pkg::skip_io_bit_set_op:
                        begin
                            // skipped length sets the cost
                            if (cond && op_next_two)
                            begin
                                nxt_pc      = pc_ff + PC_W'(3);
                                nxt_lastcyc = `BSC_CYC_SKIP2;
                                nxt_hold    = 2'd1;
                                nxt_state   = bsc_pkg::ST_HOLD;
                            end
                            else if (cond)
                            begin
                                nxt_pc      = pc_ff + PC_W'(2);
                                nxt_lastcyc = `BSC_CYC_SKIP1;
                                nxt_hold    = 2'd0;
                                nxt_state   = bsc_pkg::ST_HOLD;
                            end
                            else
                                nxt_lastcyc = `BSC_CYC_NOSKIP;
                        end
                        bsc_pkg::branch_flag_set_op,
                        bsc_pkg::branch_flag_clear_op:
                        begin
                            if (cond)
                            begin
                                nxt_pc      = br_tgt;
                                nxt_lastcyc = `BSC_CYC_BR_TAKEN;
                                nxt_hold    = 2'd0;
                                nxt_state   = bsc_pkg::ST_HOLD;
                            end
                            else
                                nxt_lastcyc = `BSC_CYC_BR_NOT;
                        end
                        bsc_pkg::indirect_load_op:
                        begin
                            nxt_req     = 1'b1;
                            nxt_addr    = x_ff;
                            nxt_lastcyc = `BSC_CYC_LOAD;
                            nxt_state   = bsc_pkg::ST_LOAD;
                        end
                        bsc_pkg::indirect_load_inc_op:
                        begin
                            nxt_req     = 1'b1;
                            nxt_addr    = x_ff;
                            nxt_x       = x_ff + 16'h0001;
                            nxt_lastcyc = `BSC_CYC_LOAD;
                            nxt_state   = bsc_pkg::ST_LOAD;
                        end
                        bsc_pkg::indirect_load_dec_op:
                        begin
                            nxt_req     = 1'b1;
                            nxt_addr    = x_ff - 16'h0001;
                            nxt_x       = x_ff - 16'h0001;
                            nxt_lastcyc = `BSC_CYC_LOAD;
                            nxt_state   = bsc_pkg::ST_LOAD;
                        end
                        default:
                            nxt_lastcyc = 2'd1;
                    endcase
                end
                else if (sw_we && !run)
                begin
                    // software may only move state while halted
                    if (sw_off == `BSC_OFF_STATUS_FLAG_REGISTER)
                        nxt_status_flag_register = pwdata[7:0];
                    if (sw_off == `BSC_OFF_PC)
                        nxt_pc = pwdata[PC_W-1:0];
                    if (sw_off == `BSC_OFF_XPTR)
                        nxt_x = pwdata[15:0];
                end
            end
            bsc_pkg::ST_HOLD:
            begin
                // extra cycles of a taken branch or skip
                if (hold_ff == 2'd0)
                    nxt_state = bsc_pkg::ST_IDLE;
                else
                    nxt_hold = hold_ff - 2'd1;
            end
            bsc_pkg::ST_LOAD:
            begin
                // data arrives while the request stands
                nxt_we    = 1'b1;
                nxt_wdata = mem_rdata;
                nxt_state = bsc_pkg::ST_IDLE;
            end
        endcase
        nxt_ready = run && (nxt_state == bsc_pkg::ST_IDLE);
    end

    // core registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= bsc_pkg::ST_IDLE;
            hold_ff    <= 2'd0;
            status_flag_register_ff    <= `BSC_STATUS_FLAG_REGISTER_RST;
            pc_ff      <= PC_W'(`BSC_PC_RST);
            x_ff       <= `BSC_XPTR_RST;
            ready_ff   <= 1'b0;
            req_ff     <= 1'b0;
            addr_ff    <= 16'h0000;
            we_ff      <= 1'b0;
            wdata_ff   <= 8'h00;
            lastcyc_ff <= 2'd0;
            taken_ff   <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            hold_ff    <= nxt_hold;
            status_flag_register_ff    <= nxt_status_flag_register;
            pc_ff      <= nxt_pc;
            x_ff       <= nxt_x;
            ready_ff   <= nxt_ready;
            req_ff     <= nxt_req;
            addr_ff    <= nxt_addr;
            we_ff      <= nxt_we;
            wdata_ff   <= nxt_wdata;
            lastcyc_ff <= nxt_lastcyc;
            taken_ff   <= nxt_taken;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, so every answer comes from a flop

    logic        pready_ff,  nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff,  nxt_prdata;
    logic        hit;

    assign sw_off = paddr;
    assign sw_we  = psel & penable & pwrite & pready_ff;
    assign hit    = (paddr == `BSC_OFF_CTRL) || (paddr == `BSC_OFF_STATUS_FLAG_REGISTER) ||
                    (paddr == `BSC_OFF_PC)   || (paddr == `BSC_OFF_XPTR) ||
                    (paddr == `BSC_OFF_STAT);

    // answer decode and control register
    always_comb
    begin
        nxt_pready  = psel & penable & ~pready_ff;
        nxt_pslverr = nxt_pready & ~hit;
        nxt_prdata  = 32'h0000_0000;
        nxt_ctrl    = ctrl_ff;
        if (nxt_pready && !pwrite)
        begin
            unique case (paddr)
                `BSC_OFF_CTRL: nxt_prdata = ctrl_ff;
                `BSC_OFF_STATUS_FLAG_REGISTER: nxt_prdata = {24'h000000, status_flag_register_ff};
                `BSC_OFF_PC:   nxt_prdata = 32'(pc_ff);
                `BSC_OFF_XPTR: nxt_prdata = {16'h0000, x_ff};
                `BSC_OFF_STAT: nxt_prdata = {28'h0000000, taken_ff,
                                             lastcyc_ff, ~ready_ff};
                default:       nxt_prdata = 32'h0000_0000;
            endcase
        end
        if (sw_we && paddr == `BSC_OFF_CTRL)
            nxt_ctrl = {31'h00000000, pwdata[`BSC_CTRL_RUN]};
    end

    // bus registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            ctrl_ff    <= `BSC_CTRL_RST;
        end
        else
        begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
            ctrl_ff    <= nxt_ctrl;
        end
    end

    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign op_ready = ready_ff;
    assign mem_req  = req_ff;
    assign mem_addr = addr_ff;
    assign rf_we    = we_ff;
    assign rf_wdata = wdata_ff;
    assign pc       = pc_ff;

    ////////////////////////////////////////////////////////////////////
    // checks

    logic is_cmp;
    logic is_skip;
    logic is_br;
    assign is_cmp  = (op_code == bsc_pkg::plain_compare_op) ||
                     (op_code == bsc_pkg::compare_with_carry_op) ||
                     (op_code == bsc_pkg::compare_immediate_op);
    assign is_skip = (op_code >= bsc_pkg::skip_reg_bit_clear_op) &&
                     (op_code <= bsc_pkg::skip_io_bit_set_op);
    assign is_br   = (op_code == bsc_pkg::branch_flag_set_op) ||
                     (op_code == bsc_pkg::branch_flag_clear_op);

    sequence s_one_stall;
        !ready_ff ##1 ready_ff;
    endsequence

    sequence s_two_stall;
        !ready_ff [*2] ##1 ready_ff;
    endsequence

    property p_cmp_one;
        @(posedge pclk) disable iff (!presetn)
        acc && is_cmp && run |=> ready_ff && pc_ff == $past(pc_ff) + 1'b1;
    endproperty
    a_cmp_one: assert property (p_cmp_one)
        else $error("compare did not finish in one cycle");

    property p_cmp_zero;
        @(posedge pclk) disable iff (!presetn)
        acc && op_code == bsc_pkg::plain_compare_op |=>
            status_flag_register_ff[`BSC_FLG_Z] == ($past(op_a) == $past(op_b)) &&
            status_flag_register_ff[`BSC_FLG_C] == ($past(op_a) < $past(op_b));
    endproperty
    a_cmp_zero: assert property (p_cmp_zero)
        else $error("compare flags wrong");

    property p_skip_none;
        @(posedge pclk) disable iff (!presetn)
        acc && is_skip && !cond && run |=>
            ready_ff && pc_ff == $past(pc_ff) + 1'b1;
    endproperty
    a_skip_none: assert property (p_skip_none)
        else $error("unskipped skip took wrong time");

    property p_skip_two;
        @(posedge pclk) disable iff (!presetn)
        acc && is_skip && cond && op_next_two && run |=>
            pc_ff == $past(pc_ff) + 2'd3 ##0 s_two_stall;
    endproperty
    a_skip_two: assert property (p_skip_two)
        else $error("two-word skip wrong");

    property p_skip_one;
        @(posedge pclk) disable iff (!presetn)
        acc && is_skip && cond && !op_next_two && run |=>
            pc_ff == $past(pc_ff) + 2'd2 ##0 s_one_stall;
    endproperty
    a_skip_one: assert property (p_skip_one)
        else $error("one-word skip wrong");

    property p_br_taken;
        @(posedge pclk) disable iff (!presetn)
        acc && is_br && cond && run |=>
            pc_ff == $past(pc_ff) + PC_W'(1) +
                     PC_W'($signed($past(op_off))) ##0 s_one_stall;
    endproperty
    a_br_taken: assert property (p_br_taken)
        else $error("taken branch wrong");

    property p_no_flags;
        @(posedge pclk) disable iff (!presetn)
        acc && (is_br || is_skip) |=> $stable(status_flag_register_ff);
    endproperty
    a_no_flags: assert property (p_no_flags)
        else $error("branch or skip changed flags");

    property p_signed_ge;
        @(posedge pclk) disable iff (!presetn)
        acc && op_code == bsc_pkg::branch_flag_clear_op &&
        op_bit == 3'(`BSC_FLG_S) |->
            cond == !(status_flag_register_ff[`BSC_FLG_N] ^ status_flag_register_ff[`BSC_FLG_V]);
    endproperty
    a_signed_ge: assert property (p_signed_ge)
        else $error("signed compare branch wrong");

    property p_ld_inc;
        @(posedge pclk) disable iff (!presetn)
        acc && op_code == bsc_pkg::indirect_load_inc_op |=>
            req_ff && addr_ff == $past(x_ff) &&
            x_ff == $past(x_ff) + 1'b1 ##1 we_ff && ready_ff;
    endproperty
    a_ld_inc: assert property (p_ld_inc)
        else $error("post-increment load wrong");

    property p_ld_dec;
        @(posedge pclk) disable iff (!presetn)
        acc && op_code == bsc_pkg::indirect_load_dec_op |=>
            req_ff && addr_ff == $past(x_ff) - 1'b1 && addr_ff == x_ff
            ##1 we_ff && wdata_ff == $past(mem_rdata);
    endproperty
    a_ld_dec: assert property (p_ld_dec)
        else $error("pre-decrement load wrong");

endmodule // bsc_core

`default_nettype wire

// ### tb/bsc_mem_model.sv
/* data memory stand-in: answers reads in the cycle of mem_req
   assumes: one clock, the core only reads through it */
`timescale 1ns/1ps
`default_nettype none
module bsc_mem_model (
    input  wire logic        pclk,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] last_ff;
    // address-derived byte; idle bus flips so stale data never matches
    always_comb mem_rdata = mem_req ? mem_addr[7:0] ^ 8'h5a : ~last_ff;
    // last value seen, flipped while idle
    always_ff @(posedge pclk) last_ff <= mem_rdata;
endmodule // bsc_mem_model
`default_nettype wire

// ### tb/branch_skip_compare_exec_test.sv
/* bench: apb setup, branches, skips, x loads and compares
   assumes: bsc_pkg, bsc_core and bsc_mem_model built first */
`include "bsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module branch_skip_compare_exec_test;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0;
    logic        pwrite = '0, op_valid = '0, op_io_bit = '0;
    logic        op_next_two = '0, go_ff = '0, c;
    logic        pready, pslverr, op_ready, mem_req, rf_we;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [7:0]  op_a = '0, op_b = '0, mem_rdata, rf_wdata, s, f;
    logic [2:0]  op_bit = '0;
    logic [6:0]  op_off = '0, k;
    logic [15:0] mem_addr, pc, epc = '0, st;
    logic [32:0] pq[$], dq[$];
    int          seed = 78640, n_errors = 0, tests_run = 0, cyc = 0, n;
    bsc_pkg::bsc_op_t op_code = bsc_pkg::plain_compare_op;
    // 125 MHz core clock
    always #4 pclk = ~pclk;
    bsc_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_ready,
        .op_code, .op_a, .op_b, .op_bit, .op_off, .op_io_bit,
        .op_next_two, .mem_req, .mem_addr, .mem_rdata, .rf_we,
        .rf_wdata, .pc);
    bsc_mem_model mem (.pclk, .mem_req, .mem_addr, .mem_rdata);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] g, e);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // idle edge at the end so back-to-back calls never double-drive
    task automatic apb(input logic w, logic [11:0] ad, logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] ad, logic [32:0] e);
        dq.push_back(e);
        apb(1'h0, ad, '0);
    endtask
    // offer the staged op, note the next pc, count busy cycles
    task automatic go(input logic [15:0] step, logic [1:0] ex);
        op_valid <= 1'h1;
        @(posedge pclk);
        while (op_ready !== 1'h1) @(posedge pclk);
        epc = epc + step;
        pq.push_back({17'h0, epc});
        op_valid <= 1'h0;
        @(posedge pclk);
        for (n = 0; op_ready !== 1'h1 && n < 8; n++)
            @(posedge pclk);
        chk(33'(n), 33'(ex));
    endtask
    ////////////////////////////////////////////////////////////////////
    // watcher: oldest note popped whenever an answer shows
    always @(posedge pclk)
    begin
        if (++cyc == 3000)
        begin
            n_errors++;
            end_of_test();
        end
        if (go_ff) chk({17'h0, pc}, pq.pop_front());
        go_ff <= op_valid & op_ready;
        if (rf_we === 1'h1) chk({25'h0, rf_wdata}, dq.pop_front());
        if ((psel & penable & pready & ~pwrite) === 1'h1)
            chk(pslverr ? 33'h1_0000_0000 : {1'h0, prdata}, dq.pop_front());
    end
    initial
    begin
        s = 8'($random(seed));
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // flags and pointer load only while stopped
        apb(1'h1, `BSC_OFF_STATUS_FLAG_REGISTER, {24'h0, s});
        apb(1'h1, `BSC_OFF_XPTR, 32'h10);
        rd(`BSC_OFF_STATUS_FLAG_REGISTER, {25'h0, s});
        rd(12'h020, 33'h1_0000_0000);
        apb(1'h1, `BSC_OFF_CTRL, 32'h1);
        apb(1'h1, `BSC_OFF_STATUS_FLAG_REGISTER, {24'h0, ~s});
        // each flag index set and clear, index 4 is n xor v
        for (int i = 0; i < 16; i++)
        begin
            k = 7'($random(seed));
            f = s;
            f[4] = s[2] ^ s[3];
            c = f[3'(i)] == (i < 8);
            st = c ? {{9{k[6]}}, k} + 16'h1 : 16'h1;
            op_code <= bsc_pkg::bsc_op_t'(i < 8 ? 4'h7 : 4'h8);
            op_bit <= 3'(i);
            op_off <= k;
            go(st, {1'h0, c});
        end
        // four skip kinds over one- and two-word successors
        for (int i = 0; i < 16; i++)
        begin
            f = 8'($random(seed));
            c = (i[1] ? i[3] : f[3'(i)]) == i[0];
            st = c ? 16'h2 + 16'(i[2]) : 16'h1;
            op_code <= bsc_pkg::bsc_op_t'(4'(i % 4 + 3));
            op_a <= f;
            op_bit <= 3'(i);
            op_io_bit <= i[3];
            op_next_two <= i[2];
            go(st, 2'(st - 16'h1));
        end
        rd(`BSC_OFF_STATUS_FLAG_REGISTER, {25'h0, s});
        // post-inc twice, pre-dec, then plain: x ends at 0x11
        for (int i = 0; i < 4; i++)
        begin
            op_code <= bsc_pkg::bsc_op_t'(i < 2 ? 4'ha : i < 3 ? 4'hb : 4'h9);
            dq.push_back(33'(8'h10 + 8'(i > 0) ^ 8'h5a));
            go(16'h1, 2'h1);
        end
        rd(`BSC_OFF_XPTR, 33'h11);
        op_a <= 8'h10;
        op_b <= 8'h20;
        op_code <= bsc_pkg::plain_compare_op;
        go(16'h1, 2'h0);
        rd(`BSC_OFF_STATUS_FLAG_REGISTER, {25'h0, s[7:6], 6'h15});
        // borrow in from C, zero chained from a cleared Z stays clear
        op_a <= 8'h20;
        op_b <= 8'h1f;
        op_code <= bsc_pkg::compare_with_carry_op;
        go(16'h1, 2'h0);
        rd(`BSC_OFF_STATUS_FLAG_REGISTER, {25'h0, s[7:6], 6'h20});
        op_a <= 8'h10;
        op_b <= 8'h10;
        op_code <= bsc_pkg::compare_immediate_op;
        go(16'h1, 2'h0);
        rd(`BSC_OFF_STATUS_FLAG_REGISTER, {25'h0, s[7:6], 6'h02});
        // last op a compare: not taken, one cycle, idle
        rd(`BSC_OFF_STAT, {29'h0, 1'b0, `BSC_CYC_CMP, 1'b0});
        rd(`BSC_OFF_CTRL, 33'h1);
        repeat (3) @(posedge pclk);
        end_of_test();
    end
endmodule // branch_skip_compare_exec_test
`default_nettype wire
